// ===== hdl/ncs_pkg.sv
// Functional notes
// [RL1] qualify cell voltage and temperature before charging
// [RL2] below 1.0V precharge at 0.125 gate duty
// [RL3] voltage above 1.0V moves precharge to fast
// [RL4] fast charge gate active 31 of 32 slots
// [RL5] impedance check in skipped slot, high impedance faults
// [RL6] fast charge ends on -2mV from peak
// [RL7] timer ends fast; temperature, voltage, impedance faults stop it
// [RL8] top-off at 12.5% for half fast timeout
// [RL9] maintenance at 1/64 until removal or power cycle; a floating timeout pin also ends it, via suspend
// [RL10] current switch high at 0.125V, low at 0.1V
// [RL11] hysteretic switching only while gate output is low
// [RL12] floating timeout pin means suspend, no charging
// [RL13] duty from repeating frame of equal slots
// [RL14] fault holds gate high until removal or power cycle
package ncs_pkg;

  // clock and slot timing
  localparam int CLK_MHZ = 25;
  localparam int SLOT_US = 1000;
  localparam int SLOT_CYCLES_DEF = SLOT_US * CLK_MHZ;
  localparam int SLOT_IDX_W = 6;

  // fast-charge timeout as programmed by the timeout resistor
  localparam int FAST_TIMEOUT_S = 7200;
  localparam int FAST_TIMEOUT_SLOTS_DEF = FAST_TIMEOUT_S * (1000000 / SLOT_US);

  // cell voltage thresholds, millivolts
  localparam logic [11:0] VCELL_MIN_MV = 12'h3e8;
  localparam logic [11:0] VCELL_MAX_MV = 12'h672;
  localparam logic [11:0] NDV_MV = 12'h002;
  localparam logic [11:0] IMP_LIMIT_MV_DEF = 12'h064;

  // duty patterns: gate on when (idx & mask) == 0, fast uses skip slot
  localparam logic [5:0] PRE_SLOT_MASK = 6'h07;
  localparam logic [5:0] MAINT_SLOT_MASK = 6'h3f;
  localparam logic [5:0] FAST_SLOT_MASK = 6'h1f;
  localparam logic [5:0] FAST_SKIP_SLOT = 6'h1f;
  localparam logic [5:0] FAST_FRAME_START = 6'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SUSPEND,
    ST_QUAL,
    ST_PRE,
    ST_FAST,
    ST_TOPOFF,
    ST_MAINT,
    ST_FAULT
  } ncs_state_e;

  // comparator and converter results from the analog front end
  typedef struct packed {
    logic [11:0] cell_mv;
    logic temp_cold;
    logic temp_hot;
    logic cs_peak;
    logic cs_valley;
  } ncs_sense_s;

  // slot timing from the slot generator
  typedef struct packed {
    logic start;
    logic [SLOT_IDX_W-1:0] idx;
  } ncs_slot_s;

endpackage : ncs_pkg

// ===== hdl/ncs_slot_gen.sv
`timescale 1ns/1ns
`default_nettype none
module ncs_slot_gen
  import ncs_pkg::*;
#(
  parameter int SLOT_CYCLES = SLOT_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  output ncs_slot_s slot
);

  localparam int CNT_W = $clog2(SLOT_CYCLES + 1);

  logic [CNT_W-1:0] cyc_q;
  logic [SLOT_IDX_W-1:0] idx_q;
  logic start_q;
  logic wrap_w;

  // elaboration guard: a one-cycle slot would hold start high for good
  if (SLOT_CYCLES < 2)
  begin : g_bad_slot
    $error("slot length must be at least two cycles");
  end

  // one slot ends when the cycle counter wraps
  assign wrap_w = (cyc_q == CNT_W'(SLOT_CYCLES - 1));

  // equal slots; the 64-slot index wraps by itself to repeat the frame
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cyc_q <= '0;
      idx_q <= '0;
      start_q <= 1'b0;
    end
    else if (ce)
    begin
      cyc_q <= wrap_w ? '0 : cyc_q + CNT_W'(1);
      idx_q <= wrap_w ? idx_q + SLOT_IDX_W'(1) : idx_q; // [RL13]
      start_q <= wrap_w;
    end
  end

  assign slot.start = start_q;
  assign slot.idx = idx_q;

endmodule : ncs_slot_gen
`default_nettype wire

// ===== hdl/ncs_charger.sv
`timescale 1ns/1ns
`default_nettype none
module ncs_charger
  import ncs_pkg::*;
#(
  parameter int SLOT_CYCLES = SLOT_CYCLES_DEF,
  parameter int FAST_TIMEOUT_SLOTS = FAST_TIMEOUT_SLOTS_DEF,
  parameter logic [11:0] IMP_LIMIT_MV = IMP_LIMIT_MV_DEF
)
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire ncs_sense_s SENSE,
  input wire logic CELL_PRESENT,
  input wire logic TIMEOUT_PROGRAM_PIN_FLOAT,
  output logic CHARGE_GATE_OUT_N,
  output logic CURRENT_SWITCH_OUT,
  output ncs_state_e CHARGE_PHASE,
  output logic FAULT
);

  // elaboration guards on the programmed timeout and impedance limit
  if (FAST_TIMEOUT_SLOTS < 4)
  begin : g_bad_timeout
    $error("fast timeout must cover at least four slots");
  end
  if (IMP_LIMIT_MV == 12'h000)
  begin : g_bad_limit
    $error("impedance limit must be non-zero");
  end

  ncs_slot_s slot;
  ncs_state_e state_q;
  ncs_state_e state_d;
  logic [31:0] timer_q;
  logic [11:0] peak_q;
  logic [11:0] v_on_q;
  logic v_on_valid_q;
  logic gate_n_q;
  logic cs_q;

  logic v_low_w;
  logic v_over_w;
  logic temp_bad_w;
  logic skip_start_w;
  logic check_w;
  logic imp_bad_w;
  logic ndv_w;
  logic fast_done_w;
  logic topoff_done_w;
  logic fast_fault_w;
  logic gate_on_w;
  logic pre_on_w;
  logic fast_on_w;
  logic maint_on_w;

  ncs_slot_gen #(
    .SLOT_CYCLES(SLOT_CYCLES)
  ) u_slot (
    .clk(CLK),
    .srst(SRST),
    .ce(CE),
    .slot(slot)
  );

  // cell window tests on the live converter value and temperature comparators
  assign v_low_w = (SENSE.cell_mv < VCELL_MIN_MV); // [RL1]
  assign v_over_w = (SENSE.cell_mv > VCELL_MAX_MV); // [RL1]
  assign temp_bad_w = SENSE.temp_cold | SENSE.temp_hot; // [RL1]

  // skip slot starts: loaded voltage is still on the cell, capture it
  assign skip_start_w = slot.start && ((slot.idx & FAST_SLOT_MASK) == FAST_SKIP_SLOT);
  // after the skip slot the cell has rested: compare rest against load
  assign check_w = (state_q == ST_FAST) && slot.start && v_on_valid_q &&
                   ((slot.idx & FAST_SLOT_MASK) == FAST_FRAME_START);
  // alkaline cells sag far more under load than nickel-metal cells
  assign imp_bad_w = check_w && (v_on_q > SENSE.cell_mv) &&
                     ((v_on_q - SENSE.cell_mv) > IMP_LIMIT_MV); // [RL5]
  // rested samples only, so ripple under load cannot fake a drop
  assign ndv_w = check_w && (peak_q > SENSE.cell_mv) &&
                 ((peak_q - SENSE.cell_mv) >= NDV_MV); // [RL6]
  assign fast_done_w = slot.start && (timer_q >= 32'(FAST_TIMEOUT_SLOTS - 1)); // [RL7]
  assign topoff_done_w = slot.start && (timer_q >= 32'(FAST_TIMEOUT_SLOTS / 2 - 1)); // [RL8]
  assign fast_fault_w = SENSE.temp_hot | SENSE.temp_cold | v_over_w | imp_bad_w; // [RL7]

  // phase sequencing; removal always wins, a fault outlasts suspend
  always_comb
  begin
    state_d = state_q;
    if (!CELL_PRESENT)
      state_d = ST_IDLE; // [RL9]
    else if (state_q == ST_FAULT)
      state_d = ST_FAULT; // [RL14]
    else if (TIMEOUT_PROGRAM_PIN_FLOAT)
      state_d = ST_SUSPEND; // [RL12]
    else
    begin
      unique case (state_q)
        ST_IDLE:
          state_d = ST_QUAL;
        ST_SUSPEND:
          state_d = ST_QUAL;
        ST_QUAL:
          // waits here while temperature is out of window or the cell is over voltage; a low cell goes on to precharge
          if (slot.start && !temp_bad_w && !v_over_w)
            state_d = v_low_w ? ST_PRE : ST_FAST; // [RL1] [RL2]
        ST_PRE:
          if (temp_bad_w || v_over_w)
            state_d = ST_FAULT;
          else if (slot.start && !v_low_w)
            state_d = ST_FAST; // [RL3]
        ST_FAST:
          if (fast_fault_w)
            state_d = ST_FAULT; // [RL7]
          else if (ndv_w || fast_done_w)
            state_d = ST_TOPOFF; // [RL6] [RL7]
        ST_TOPOFF:
          if (topoff_done_w)
            state_d = ST_MAINT; // [RL8]
        ST_MAINT:
          state_d = ST_MAINT; // [RL9]
        ST_FAULT:
          state_d = ST_FAULT;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      state_q <= ST_IDLE;
    else if (CE)
      state_q <= state_d;
  end

  // slot timer restarts on every phase change
  always_ff @(posedge CLK)
  begin
    if (SRST)
      timer_q <= '0;
    else if (CE)
    begin
      if (state_d != state_q)
        timer_q <= '0;
      else if (slot.start && (state_q == ST_FAST || state_q == ST_TOPOFF))
        timer_q <= timer_q + 32'h0000_0001; // [RL7] [RL8]
    end
  end

  // loaded sample and rested peak for the fast phase
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      v_on_q <= '0;
      v_on_valid_q <= 1'b0;
      peak_q <= '0;
    end
    else if (CE)
    begin
      if (state_q != ST_FAST)
      begin
        v_on_valid_q <= 1'b0;
        peak_q <= '0;
      end
      else
      begin
        if (skip_start_w)
        begin
          v_on_q <= SENSE.cell_mv; // [RL5]
          v_on_valid_q <= 1'b1;
        end
        if (check_w && SENSE.cell_mv > peak_q)
          peak_q <= SENSE.cell_mv; // [RL6]
      end
    end
  end

  // gate duty per phase from the slot index
  assign pre_on_w = ((slot.idx & PRE_SLOT_MASK) == 6'h00); // [RL2] [RL8]
  assign fast_on_w = ((slot.idx & FAST_SLOT_MASK) != FAST_SKIP_SLOT); // [RL4]
  assign maint_on_w = ((slot.idx & MAINT_SLOT_MASK) == 6'h00); // [RL9]
  assign gate_on_w = ((state_q == ST_PRE || state_q == ST_TOPOFF) && pre_on_w) ||
                     ((state_q == ST_FAST) && fast_on_w) ||
                     ((state_q == ST_MAINT) && maint_on_w); // [RL13]

  // gate is active low; fault, suspend and idle leave it high
  always_ff @(posedge CLK)
  begin
    if (SRST)
      gate_n_q <= 1'b1;
    else if (CE)
      gate_n_q <= ~gate_on_w; // [RL14] [RL12]
  end

  // hysteretic current switch, held low while the gate is high
  always_ff @(posedge CLK)
  begin
    if (SRST)
      cs_q <= 1'b0;
    else if (CE)
    begin
      if (gate_n_q)
        cs_q <= 1'b0; // [RL11]
      else if (SENSE.cs_peak)
        cs_q <= 1'b1; // [RL10]
      else if (SENSE.cs_valley)
        cs_q <= 1'b0; // [RL10]
    end
  end

  assign CHARGE_GATE_OUT_N = gate_n_q;
  assign CURRENT_SWITCH_OUT = cs_q;
  assign CHARGE_PHASE = state_q;
  assign FAULT = (state_q == ST_FAULT);

  // checks on the sequencing and outputs
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  sequence s_skip_slot;
    CE && (state_q == ST_FAST) && skip_start_w && CELL_PRESENT && !TIMEOUT_PROGRAM_PIN_FLOAT;
  endsequence

  sequence s_fast_check;
    CE && (state_q == ST_FAST) && check_w && CELL_PRESENT && !TIMEOUT_PROGRAM_PIN_FLOAT;
  endsequence

  sequence s_in_fault;
    CE && (state_q == ST_FAULT) && CELL_PRESENT;
  endsequence

  a_qual_window: assert property ( // [RL1]
    CE && state_q == ST_QUAL && (temp_bad_w || v_over_w) |=> state_q != ST_PRE && state_q != ST_FAST)
    else $error("charging began outside the qualification window");

  a_pre_entry: assert property ( // [RL2]
    CE && state_q == ST_QUAL && CELL_PRESENT && !TIMEOUT_PROGRAM_PIN_FLOAT && slot.start &&
    !temp_bad_w && !v_over_w && v_low_w |=> state_q == ST_PRE)
    else $error("low cell did not enter precharge");

  a_pre_to_fast: assert property ( // [RL3]
    CE && state_q == ST_PRE && CELL_PRESENT && !TIMEOUT_PROGRAM_PIN_FLOAT && slot.start &&
    !temp_bad_w && !v_over_w && !v_low_w |=> state_q == ST_FAST)
    else $error("precharge did not move to fast charge");

  a_fast_skip: assert property ( // [RL4]
    s_skip_slot |=> CHARGE_GATE_OUT_N)
    else $error("gate active in the fast charge skip slot");

  a_imp_fault: assert property ( // [RL5]
    s_fast_check ##0 imp_bad_w |=> state_q == ST_FAULT ##1 CHARGE_GATE_OUT_N)
    else $error("high impedance cell not faulted");

  a_ndv_end: assert property ( // [RL6]
    s_fast_check ##0 (ndv_w && !fast_fault_w) |=> state_q == ST_TOPOFF)
    else $error("negative voltage change did not end fast charge");

  a_fast_timer: assert property ( // [RL7]
    CE && state_q == ST_FAST && CELL_PRESENT && !TIMEOUT_PROGRAM_PIN_FLOAT && !fast_fault_w &&
    slot.start && timer_q == 32'(FAST_TIMEOUT_SLOTS - 1) |=> state_q == ST_TOPOFF)
    else $error("fast timer expiry did not end fast charge");

  a_topoff_len: assert property ( // [RL8]
    CE && state_q == ST_TOPOFF |-> timer_q < 32'(FAST_TIMEOUT_SLOTS / 2))
    else $error("top-off ran past half the fast timeout");

  a_maint_hold: assert property ( // [RL9]
    CE && state_q == ST_MAINT && CELL_PRESENT && !TIMEOUT_PROGRAM_PIN_FLOAT |=> state_q == ST_MAINT)
    else $error("maintenance left while cell present");

  a_cs_rise: assert property ( // [RL10]
    CE && !CHARGE_GATE_OUT_N && SENSE.cs_peak |=> CURRENT_SWITCH_OUT)
    else $error("current switch did not rise at peak");

  a_cs_gated: assert property ( // [RL11]
    CE && CHARGE_GATE_OUT_N |=> !CURRENT_SWITCH_OUT)
    else $error("current switch active while gate high");

  a_suspend: assert property ( // [RL12]
    CE && CELL_PRESENT && TIMEOUT_PROGRAM_PIN_FLOAT && state_q != ST_FAULT
    |=> state_q == ST_SUSPEND ##1 CHARGE_GATE_OUT_N)
    else $error("floating timeout pin did not suspend charging");

  a_fault_latch: assert property ( // [RL14]
    s_in_fault |=> state_q == ST_FAULT && CHARGE_GATE_OUT_N)
    else $error("fault released while cell present");

  // outside its active slots the gate must stay high
  a_pre_duty: assert property ( // [RL2]
    CE && state_q == ST_PRE && slot.idx[2:0] != 3'h0 |=> CHARGE_GATE_OUT_N)
    else $error("precharge gate active outside its slot");

  a_maint_duty: assert property ( // [RL9]
    CE && state_q == ST_MAINT && slot.idx != 6'h00 |=> CHARGE_GATE_OUT_N)
    else $error("maintenance gate active outside its slot");

  a_fast_fault: assert property ( // [RL7]
    CE && state_q == ST_FAST && CELL_PRESENT && !TIMEOUT_PROGRAM_PIN_FLOAT &&
    (SENSE.temp_hot || SENSE.temp_cold || v_over_w) |=> state_q == ST_FAULT)
    else $error("temperature or voltage fault did not stop fast charge");

  a_cs_fall: assert property ( // [RL10]
    CE && !CHARGE_GATE_OUT_N && !SENSE.cs_peak && SENSE.cs_valley |=> !CURRENT_SWITCH_OUT)
    else $error("current switch did not fall at valley");

  a_cell_removal: assert property ( // [RL14]
    CE && !CELL_PRESENT |=> state_q == ST_IDLE)
    else $error("cell removal did not return to idle");

  // a low enable must freeze the frame too, or duty would drift
  a_freeze_hold: assert property ( // [RL13]
    !CE |=> $stable(state_q) && $stable(slot.idx) &&
    $stable(CHARGE_GATE_OUT_N) && $stable(CURRENT_SWITCH_OUT))
    else $error("state moved while the clock enable was low");

endmodule : ncs_charger
`default_nettype wire

// ===== test/ncs_cell_model.sv
`timescale 1ns/1ns
`default_nettype none
// one cell behind the buck stage: bench sets the rest voltage, current follows gate and switch
module ncs_cell_model
  import ncs_pkg::*;
(
  input wire logic clk,
  input wire logic gate_n,
  input wire logic sw_off,
  input wire logic [11:0] rest_mv,
  input wire logic [11:0] imp_mv,
  input wire logic cold,
  input wire logic hot,
  output ncs_sense_s sense
);
  logic [4:0] cur_q = 5'h00;
  // inductor ramps only with gate low and switch on, decays otherwise
  always @(posedge clk)
  begin
    if (!gate_n && !sw_off && cur_q != 5'h1f)
      cur_q <= cur_q + 5'h01;
    else if ((gate_n || sw_off) && cur_q != 5'h00)
      cur_q <= cur_q - 5'h01;
  end
  // a weak cell shows a large gap between loaded and rested voltage
  assign sense.cell_mv = gate_n ? rest_mv : rest_mv + imp_mv;
  assign sense.temp_cold = cold;
  assign sense.temp_hot = hot;
  assign sense.cs_peak = cur_q >= 5'h0a;
  assign sense.cs_valley = cur_q <= 5'h08;
endmodule : ncs_cell_model
`default_nettype wire

// ===== test/ncs_charger_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module ncs_charger_bench
  import ncs_pkg::*;
;
  localparam int SC = 4;
  localparam int FTS = 128;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b0, present = 1'b0, flt = 1'b0, cold = 1'b0, hot = 1'b0;
  logic [11:0] rest_mv = 12'h000, imp_mv = 12'h000;
  logic gate_n, sw, fault, pv_gate = 1'b1, pv_peak = 1'b0, pv_valley = 1'b0;
  ncs_sense_s sense;
  ncs_state_e phase, last_ph = ST_IDLE, note;
  ncs_state_e expq[$];
  int bad_count = 0, checks = 0, cyc = 0, n, l;
  logic [31:0] seed = 32'h819c;

  always #20 clk = ~clk;

  ncs_charger #(.SLOT_CYCLES(SC), .FAST_TIMEOUT_SLOTS(FTS)) u_ncs_charger (.CLK(clk), .SRST(srst), .CE(ce),
    .SENSE(sense), .CELL_PRESENT(present), .TIMEOUT_PROGRAM_PIN_FLOAT(flt), .CHARGE_GATE_OUT_N(gate_n),
    .CURRENT_SWITCH_OUT(sw), .CHARGE_PHASE(phase), .FAULT(fault));
  ncs_cell_model u_ncs_cell_model (.clk(clk), .gate_n(gate_n), .sw_off(sw), .rest_mv(rest_mv),
    .imp_mv(imp_mv), .cold(cold), .hot(hot), .sense(sense));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic step;
    @(posedge clk);
    #2;
  endtask : step

  // bounded wait for a phase, then compare
  task automatic wait_ph(input ncs_state_e p, input int lim, output int k);
    k = 0;
    while (phase !== p && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    `CHK("phase", p, phase)
  endtask : wait_ph

  // counts enabled gate cycles; any whole frame gives an exact figure
  task automatic duty(input int len, output int lows);
    lows = 0;
    repeat (len)
    begin
      @(negedge clk);
      if (gate_n === 1'b0)
        lows++;
    end
  endtask : duty

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // phase notes are taken off the queue as each change appears; switch checked against sense
  always @(negedge clk)
  begin
    if (!srst && phase !== last_ph)
    begin
      note = (expq.size() != 0) ? expq.pop_front() : last_ph;
      `CHK("phase step", note, phase)
      last_ph = phase;
    end
    if (!srst && pv_gate && gate_n)
      `CHK("switch gated", 1'b0, sw)
    else if (!srst && !pv_gate && !gate_n && pv_peak)
      `CHK("switch peak", 1'b1, sw)
    else if (!srst && !pv_gate && !gate_n && pv_valley)
      `CHK("switch valley", 1'b0, sw)
    pv_gate = gate_n;
    pv_peak = sense.cs_peak;
    pv_valley = sense.cs_valley;
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (10) step();
    `CHK("reset gate", 1'b1, gate_n)
    `CHK("reset phase", ST_IDLE, phase)
    `CHK("reset switch", 1'b0, sw)
    srst = 1'b0;
    ce = 1'b1;
    seed = xs(seed);
    expq.push_back(ST_SUSPEND);
    flt = 1'b1;
    present = 1'b1;
    rest_mv = 12'h320 + {5'h00, seed[6:0]};
    wait_ph(ST_SUSPEND, 8, n);
    duty(64, l);
    `CHK("suspend duty", 0, l)
    expq.push_back(ST_QUAL);
    expq.push_back(ST_PRE);
    step();
    flt = 1'b0;
    wait_ph(ST_PRE, 40, n);
    duty(256, l);
    `CHK("pre duty", 32, l)
    expq.push_back(ST_FAST);
    step();
    rest_mv = 12'h44c + {3'h0, seed[16:8]};
    wait_ph(ST_FAST, 20, n);
    duty(256, l);
    `CHK("fast duty", 248, l)
    expq.push_back(ST_TOPOFF);
    wait_ph(ST_TOPOFF, 400, n);
    `CHK("fast length", 1'b1, (n + 256 >= 500) && (n + 256 <= 520))
    expq.push_back(ST_MAINT);
    duty(128, l);
    `CHK("topoff duty", 16, l)
    wait_ph(ST_MAINT, 300, n);
    `CHK("topoff length", 1'b1, (n + 128 >= 240) && (n + 128 <= 264))
    duty(512, l);
    `CHK("maint duty", 8, l)
    `CHK("maint holds", ST_MAINT, phase)
    $display("test full cycle done");
    expq.push_back(ST_IDLE);
    expq.push_back(ST_QUAL);
    expq.push_back(ST_FAST);
    step();
    present = 1'b0;
    wait_ph(ST_IDLE, 4, n);
    step();
    present = 1'b1;
    rest_mv = 12'h514;
    wait_ph(ST_FAST, 40, n);
    repeat (150) step();
    expq.push_back(ST_TOPOFF);
    rest_mv = rest_mv - 12'h002;
    wait_ph(ST_TOPOFF, 300, n);
    $display("test negative delta done");
    expq.push_back(ST_IDLE);
    expq.push_back(ST_QUAL);
    expq.push_back(ST_FAST);
    expq.push_back(ST_FAULT);
    step();
    present = 1'b0;
    imp_mv = 12'h096;
    wait_ph(ST_IDLE, 4, n);
    step();
    present = 1'b1;
    wait_ph(ST_FAULT, 400, n);
    `CHK("fault flag", 1'b1, fault)
    step();
    flt = 1'b1;
    duty(64, l);
    `CHK("fault duty", 0, l)
    `CHK("fault holds", ST_FAULT, phase)
    // enable low: even a removal must not move the frozen fault
    step();
    ce = 1'b0;
    present = 1'b0;
    repeat (8) step();
    `CHK("frozen phase", ST_FAULT, phase)
    `CHK("frozen gate", 1'b1, gate_n)
    ce = 1'b1;
    present = 1'b1;
    $display("test impedance done");
    expq.push_back(ST_IDLE);
    expq.push_back(ST_QUAL);
    step();
    present = 1'b0;
    flt = 1'b0;
    imp_mv = 12'h000;
    cold = 1'b1;
    rest_mv = 12'h6a4;
    wait_ph(ST_IDLE, 4, n);
    step();
    present = 1'b1;
    wait_ph(ST_QUAL, 4, n);
    duty(64, l);
    step();
    cold = 1'b0;
    duty(64, n);
    `CHK("qual refused", 0, l + n)
    `CHK("qual waits", ST_QUAL, phase)
    expq.push_back(ST_FAST);
    expq.push_back(ST_FAULT);
    step();
    rest_mv = 12'h4b0;
    wait_ph(ST_FAST, 20, n);
    repeat (40) step();
    hot = 1'b1;
    wait_ph(ST_FAULT, 4, n);
    duty(32, l);
    `CHK("hot gate", 0, l)
    $display("test qualification done");
    give_verdict();
  end
endmodule : ncs_charger_bench
`default_nettype wire
